// ---- i2csl_slave.sv ----
// Two-wire bus slave: address match, events, clock stretching
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module i2csl_slave #(
  parameter int unsigned LOW_CYC = i2csl_pkg::LOW_CYCLES,
  parameter int unsigned RX_DEPTH = i2csl_pkg::FIFO_DEPTH
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [i2csl_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [i2csl_pkg::WB_DW-1:0] wb_dat_i,
  output logic                            wb_ack_o,
  output logic      [i2csl_pkg::WB_DW-1:0] wb_dat_o,
  input  wire logic                       scl_i,
  output logic                            scl_o,
  output logic                            scl_oe_o,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_o,
  input  wire logic                       arb_lost_i,
  output logic                            master_role_status_o,
  output logic                            transmit_direction_status_o,
  output logic                            service_pending_flag_o,
  output logic      [2:0]                 word_bit_count_o,
  output logic                            serial_bus_interrupt_o
);
  import i2csl_pkg::*;

  typedef struct packed {
    i2csl_state_t         st;
    logic                 scl_s1;
    logic                 scl_s2;
    logic                 scl_d;
    logic                 sda_s1;
    logic                 sda_s2;
    logic                 sda_d;
    logic [3:0]           bit_cnt;
    logic [3:0]           wlen;
    logic [7:0]           shift;
    logic [7:0]           tx_buf;
    logic                 is_tx;
    logic [LOW_CNT_W-1:0] low_cnt;
    logic                 mst;
    logic                 trx;
    logic                 al;
    logic                 aas;
    logic                 gc;
    logic                 lrb;
    logic                 pin;
    logic [2:0]           bc;
    logic                 nack_dis;
    logic [6:0]           own;
    logic                 line_lvl;
    logic                 scl_oe;
    logic                 sda_oe;
    logic                 irq;
    logic                 wb_ack;
    logic [WB_DW-1:0]     wb_dat;
    logic                 rx_pop;
    logic                 rx_push;
    logic [7:0]           rx_data;
  } i2csl_regs_t;

  localparam i2csl_regs_t RST_REGS = '{
    st:       ST_IDLE,
    pin:      RST_PIN,
    bc:       RST_BC,
    nack_dis: RST_NACK,
    own:      RST_OWN,
    scl_s1:   1'b1,
    scl_s2:   1'b1,
    scl_d:    1'b1,
    sda_s1:   1'b1,
    sda_s2:   1'b1,
    sda_d:    1'b1,
    default:  '0
  };

  i2csl_regs_t r;
  i2csl_regs_t n;

  logic       bus_req;
  logic       data_wr;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       own_hit;
  logic       gc_hit;
  logic       rx_in_ready;
  logic       rx_valid;
  logic [7:0] rx_q;
  logic [7:0] status;
  logic       raise;

  i2csl_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (r.rx_push),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (r.rx_data),
    .out_valid_o (rx_valid),
    .out_ready_i (r.rx_pop),
    .out_data_o  (rx_q)
  );

  assign bus_req   = wb_cyc_i && wb_stb_i && !r.wb_ack;
  assign data_wr   = bus_req && wb_we_i && wb_sel_i[0] &&
                     (wb_adr_i == OFS_DATA_BUFFER);
  // Only the second and third sync stages feed edge logic
  assign scl_rise  = r.scl_s2 && !r.scl_d;
  assign scl_fall  = !r.scl_s2 && r.scl_d;
  assign start_det = r.scl_s2 && r.scl_d && r.sda_d && !r.sda_s2;
  assign stop_det  = r.scl_s2 && r.scl_d && !r.sda_d && r.sda_s2;
  assign own_hit   = (r.shift[7:1] == r.own);
  assign gc_hit    = (r.shift == GC_ADDRESS);

  always_comb begin
    status = '0;
    status[SR_LRB_BIT] = r.lrb;
    status[SR_GC_BIT]  = r.gc;
    status[SR_AAS_BIT] = r.aas;
    status[SR_AL_BIT]  = r.al;
    status[SR_PIN_BIT] = r.pin;
    status[SR_RXV_BIT] = rx_valid;
    status[SR_TRX_BIT] = r.trx;
    status[SR_MST_BIT] = r.mst;
  end

  always_comb begin
    n = r;
    raise = 1'b0;
    n.scl_s1 = scl_i;
    n.scl_s2 = r.scl_s1;
    n.scl_d  = r.scl_s2;
    n.sda_s1 = sda_i;
    n.sda_s2 = r.sda_s1;
    n.sda_d  = r.sda_s2;
    n.irq     = 1'b0;
    n.wb_ack  = 1'b0;
    n.rx_pop  = 1'b0;
    n.rx_push = 1'b0;

    // Register slave; answers every address, unmapped reads as zero
    if (bus_req) begin
      n.wb_ack = 1'b1;
      n.wb_dat = '0;
      case (wb_adr_i)
        OFS_DATA_BUFFER: begin
          // Empty FIFO reads as zero, never a stale entry
          n.wb_dat[7:0] = rx_valid ? rx_q : 8'h00;
          if (!wb_we_i && rx_valid) begin
            n.rx_pop = 1'b1;
          end
          if (data_wr) begin
            n.tx_buf = wb_dat_i[7:0];
            n.pin = 1'b1;
            if (r.al && !r.aas) begin
              n.al = 1'b0;
            end
          end
        end
        OFS_BUS_CONTROL_ONE: begin
          n.wb_dat[CR1_BC_LSB +: 3] = r.bc;
          n.wb_dat[CR1_NACK_BIT]    = r.nack_dis;
          if (wb_we_i && wb_sel_i[0]) begin
            n.bc       = wb_dat_i[CR1_BC_LSB +: 3];
            n.nack_dis = wb_dat_i[CR1_NACK_BIT];
          end
        end
        OFS_BUS_CONTROL_TWO: begin
          n.wb_dat[CR2_PIN_BIT] = r.pin;
          n.wb_dat[CR2_TRX_BIT] = r.trx;
          n.wb_dat[CR2_MST_BIT] = r.mst;
          if (wb_we_i && wb_sel_i[0]) begin
            // Pending can only be set by software, never cleared
            if (wb_dat_i[CR2_PIN_BIT]) begin
              n.pin = 1'b1;
            end
            n.trx = wb_dat_i[CR2_TRX_BIT];
            n.mst = wb_dat_i[CR2_MST_BIT];
          end
        end
        OFS_BUS_STATUS: begin
          n.wb_dat[7:0] = status;
        end
        OFS_OWN_ADDRESS: begin
          n.wb_dat[OWN_SA_LSB +: 7] = r.own;
          if (wb_we_i && wb_sel_i[0]) begin
            n.own = wb_dat_i[OWN_SA_LSB +: 7];
          end
        end
        default: begin
        end
      endcase
    end

    case (r.st)
      ST_IDLE: begin
      end
      ST_ADDR: begin
        if (scl_rise) begin
          n.shift   = {r.shift[6:0], r.sda_s2};
          n.bit_cnt = r.bit_cnt + 4'h1;
        end else if (scl_fall && r.bit_cnt == ADDR_BITS) begin
          // Detection only while the ack clock is enabled
          if (!r.nack_dis && (own_hit || gc_hit)) begin
            n.aas    = 1'b1;
            n.gc     = gc_hit;
            n.trx    = r.shift[0];
            n.sda_oe = 1'b1;
            n.st     = ST_ACK;
          end else begin
            n.st = ST_SKIP;
          end
        end
      end
      ST_ACK: begin
        if (scl_rise) begin
          n.lrb = r.sda_s2;
        end else if (scl_fall) begin
          n.sda_oe = 1'b0;
          raise = 1'b1;
        end
      end
      ST_HOLD: begin
        if (r.pin) begin
          if (r.low_cnt == LOW_CNT_W'(LOW_CYC - 1)) begin
            n.scl_oe  = 1'b0;
            n.bit_cnt = '0;
            n.wlen    = (r.bc == 3'h0) ? FULL_BITS : {1'b0, r.bc};
            n.is_tx   = r.trx;
            if (!r.aas) begin
              n.st = ST_SKIP;
            end else begin
              n.st = ST_DATA;
              if (r.trx) begin
                n.sda_oe = !r.tx_buf[7];
                n.shift  = {r.tx_buf[6:0], 1'b0};
              end
            end
          end else begin
            n.low_cnt = r.low_cnt + 1'b1;
          end
        end
      end
      ST_DATA: begin
        if (scl_rise) begin
          n.bit_cnt = r.bit_cnt + 4'h1;
          if (!r.is_tx) begin
            n.shift = {r.shift[6:0], r.sda_s2};
          end
        end else if (scl_fall) begin
          if (r.bit_cnt == r.wlen) begin
            if (r.is_tx) begin
              n.sda_oe = 1'b0;
              if (r.nack_dis) begin
                raise = 1'b1;
              end else begin
                n.st = ST_ACK;
              end
            end else begin
              // Stretch here until the receive FIFO has room
              n.scl_oe = 1'b1;
              n.st     = ST_PUSH;
            end
          end else if (r.is_tx) begin
            n.sda_oe = !r.shift[7];
            n.shift  = {r.shift[6:0], 1'b0};
          end
        end
      end
      ST_PUSH: begin
        if (rx_in_ready) begin
          n.rx_push = 1'b1;
          n.rx_data = r.shift;
          if (r.nack_dis) begin
            raise = 1'b1;
          end else begin
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b1;
            n.st     = ST_ACK;
          end
        end
      end
      ST_SKIP: begin
        if (scl_fall) begin
          if (r.bit_cnt == SKIP_LAST) begin
            n.bit_cnt = '0;
            if (r.al) begin
              raise = 1'b1;
            end
          end else begin
            n.bit_cnt = r.bit_cnt + 4'h1;
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Applied after bus writes so a hardware event beats a software set
    if (raise) begin
      n.irq     = 1'b1;
      n.pin     = 1'b0;
      n.scl_oe  = 1'b1;
      n.low_cnt = '0;
      n.st      = ST_HOLD;
    end
    if (start_det) begin
      n.st      = ST_ADDR;
      n.bit_cnt = '0;
      n.aas     = 1'b0;
      n.gc      = 1'b0;
      n.sda_oe  = 1'b0;
      n.scl_oe  = 1'b0;
    end else if (stop_det) begin
      n.st     = ST_IDLE;
      n.aas    = 1'b0;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
    end
    if (arb_lost_i && r.mst) begin
      n.mst = 1'b0;
      n.al  = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= RST_REGS;
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o                    = r.wb_ack;
  assign wb_dat_o                    = r.wb_dat;
  assign scl_o                       = r.line_lvl;
  assign scl_oe_o                    = r.scl_oe;
  assign sda_o                       = r.line_lvl;
  assign sda_oe_o                    = r.sda_oe;
  assign master_role_status_o        = r.mst;
  assign transmit_direction_status_o = r.trx;
  assign service_pending_flag_o      = r.pin;
  assign word_bit_count_o            = r.bc;
  assign serial_bus_interrupt_o      = r.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_ack_end;
    r.st == ST_ACK && scl_fall && !start_det && !stop_det;
  endsequence

  sequence s_event;
    r.irq && !r.pin && r.scl_oe && r.st == ST_HOLD;
  endsequence

  sequence s_addr_done;
    r.st == ST_ADDR && scl_fall && r.bit_cnt == ADDR_BITS &&
      !start_det && !stop_det;
  endsequence

  a_ack_end_irq: assert property (s_ack_end |=> s_event)
    else $error("ack end did not raise the event");

  a_own_match: assert property (
    s_addr_done ##0 (own_hit && !r.nack_dis) |=> r.st == ST_ACK ##1
      (r.sda_oe && r.aas))
    else $error("own address match not acknowledged");

  a_gc_match: assert property (
    s_addr_done ##0 (gc_hit && !r.nack_dis) |=> r.gc && r.aas && !r.trx)
    else $error("general call not flagged");

  a_gc_only_zero: assert property ($rose(r.gc) |->
    $past(r.shift) == GC_ADDRESS && r.aas)
    else $error("general call flag without zero byte");

  a_nack_no_det: assert property (
    s_addr_done ##0 r.nack_dis |=> r.st == ST_SKIP && !r.aas)
    else $error("address detected with ack disabled");

  a_start_byte: assert property (
    s_addr_done ##0 (r.own == 7'h00 && r.shift == 8'h01 && !r.nack_dis)
      |=> r.aas && r.trx)
    else $error("start byte did not set transmitter status");

  a_event_stretch: assert property (
    r.irq |-> !r.pin && r.scl_oe ##1 r.scl_oe)
    else $error("event without pending clear and stretch");

  a_arb_to_slave: assert property (
    arb_lost_i && r.mst |=> !r.mst && r.al)
    else $error("arbitration loss did not fall back");

  a_arb_word_irq: assert property (
    r.st == ST_SKIP && scl_fall && r.bit_cnt == SKIP_LAST && r.al &&
      !start_det && !stop_det |=> s_event)
    else $error("lost word end did not raise the event");

  a_dummy_clr_al: assert property (
    data_wr && r.al && !r.aas && !(arb_lost_i && r.mst) |=> !r.al && r.pin)
    else $error("dummy write did not clear lost flag");

  a_release_time: assert property (
    $fell(r.scl_oe) && $past(r.st) == ST_HOLD &&
      (r.st == ST_DATA || r.st == ST_SKIP) |->
      $past(r.low_cnt) == LOW_CNT_W'(LOW_CYC - 1) && $past(r.pin))
    else $error("clock released at the wrong time");

  a_hold_keeps: assert property (
    r.st == ST_HOLD && !r.pin |-> r.scl_oe)
    else $error("clock let go while pending is clear");

  a_dir_status: assert property ($rose(r.aas) |->
    r.trx == $past(r.shift[0]))
    else $error("direction status does not follow address");

endmodule : i2csl_slave

// ---- i2csl_pkg.sv ----
// Shared constants and types for the two-wire slave event block
package i2csl_pkg;

  // Timing: system clock and released-clock low period
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned LOW_TIME_NS   = 5000;
  localparam int unsigned LOW_CYCLES    =
    (LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOW_CNT_W     = $clog2(LOW_CYCLES + 1);

  // Register bus
  localparam int unsigned WB_AW = 8;
  localparam int unsigned WB_DW = 32;
  localparam logic [7:0] OFS_DATA_BUFFER     = 8'h00;
  localparam logic [7:0] OFS_BUS_CONTROL_ONE = 8'h04;
  localparam logic [7:0] OFS_BUS_CONTROL_TWO = 8'h08;
  localparam logic [7:0] OFS_BUS_STATUS      = 8'h0C;
  localparam logic [7:0] OFS_OWN_ADDRESS     = 8'h10;

  // Field positions
  localparam int unsigned CR1_BC_LSB   = 0;
  localparam int unsigned CR1_NACK_BIT = 4;
  localparam int unsigned CR2_PIN_BIT  = 4;
  localparam int unsigned CR2_TRX_BIT  = 6;
  localparam int unsigned CR2_MST_BIT  = 7;
  localparam int unsigned OWN_SA_LSB   = 1;
  localparam int unsigned SR_LRB_BIT   = 0;
  localparam int unsigned SR_GC_BIT    = 1;
  localparam int unsigned SR_AAS_BIT   = 2;
  localparam int unsigned SR_AL_BIT    = 3;
  localparam int unsigned SR_PIN_BIT   = 4;
  localparam int unsigned SR_RXV_BIT   = 5;
  localparam int unsigned SR_TRX_BIT   = 6;
  localparam int unsigned SR_MST_BIT   = 7;

  // Reset values
  localparam logic       RST_PIN  = 1'b1;
  localparam logic       RST_NACK = 1'b0;
  localparam logic [2:0] RST_BC   = 3'h0;
  localparam logic [6:0] RST_OWN  = 7'h00;

  // Word framing
  localparam logic [7:0] GC_ADDRESS = 8'h00;
  localparam logic [3:0] ADDR_BITS  = 4'h8;
  localparam logic [3:0] FULL_BITS  = 4'h8;
  localparam logic [3:0] SKIP_LAST  = 4'h8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b010,
    ST_HOLD = 3'b011,
    ST_DATA = 3'b100,
    ST_PUSH = 3'b101,
    ST_SKIP = 3'b110
  } i2csl_state_t;

endpackage : i2csl_pkg

// ---- i2csl_fifo.sv ----
// Receive word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module i2csl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } i2csl_fifo_t;

  i2csl_fifo_t r;
  i2csl_fifo_t n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o  = (r.count != (AW+1)'(DEPTH));
  assign out_valid_o = (r.count != '0);
  assign out_data_o  = mem[r.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;

  always_comb begin
    n = r;
    if (push) begin
      n.wr_ptr = (r.wr_ptr == AW'(DEPTH - 1)) ? '0 : r.wr_ptr + 1'b1;
    end
    if (pop) begin
      n.rd_ptr = (r.rd_ptr == AW'(DEPTH - 1)) ? '0 : r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      n.count = r.count + 1'b1;
    end else if (pop && !push) begin
      n.count = r.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Storage carries no reset, only the pointers and the count need one
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[r.wr_ptr] <= in_data_i;
    end
  end

endmodule : i2csl_fifo

// ---- i2csl_master_mdl.sv ----
// Behavioural two-wire bus master facing the slave under test
`timescale 1ns/1ps
module i2csl_master_mdl (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Open drain: 1 releases the line, the pull-up makes it high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Waits on the wire, so a held clock line stalls the master
  task automatic clk_pulse(output logic s);
    scl_o <= 1'b1;
    tick(1);
    while (scl_i !== 1'b1) tick(1);
    tick(2);
    s = sda_i;
    tick(2);
    scl_o <= 1'b0;
    tick(4);
  endtask : clk_pulse

  task automatic start;
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
    tick(4);
  endtask : start

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_o <= b[i];
      tick(1);
      clk_pulse(s);
    end
    sda_o <= 1'b1;
    tick(1);
    clk_pulse(ack);
  endtask : put_byte

  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    sda_o <= 1'b1;
    for (int i = 7; i >= 0; i--) clk_pulse(b[i]);
    sda_o <= nack;
    tick(1);
    clk_pulse(s);
    sda_o <= 1'b1;
  endtask : get_byte

  task automatic stop;
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(1);
    while (scl_i !== 1'b1) tick(1);
    tick(4);
    sda_o <= 1'b1;
    tick(8);
  endtask : stop
endmodule : i2csl_master_mdl

// ---- i2csl_slave_tb_top.sv ----
// Self-checking bench for the two-wire slave event block
`timescale 1ns/1ps
module i2csl_slave_tb_top;
  import i2csl_pkg::*;
  localparam int unsigned LOWC = 4;
  logic        clk_i, rst_i, cyc, stb, we, arb, ack;
  logic [7:0]  adr;
  logic [31:0] wdat, dat_o, rdat;
  logic        scl_oe, sda_oe, scl_m, sda_m, mst, trx, pin, irq, a;
  logic        scl_lv, sda_lv;
  logic [2:0]  bc;
  logic [7:0]  b;
  int          miscompares, n_checks, irq_n, n, cnt;
  wire scl_w = scl_m & ~scl_oe;
  wire sda_w = sda_m & ~sda_oe;

  i2csl_slave #(.LOW_CYC(LOWC), .RX_DEPTH(16)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_ack_o(ack), .wb_dat_o(dat_o), .scl_i(scl_w), .scl_o(scl_lv),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_lv), .sda_oe_o(sda_oe),
    .arb_lost_i(arb), .master_role_status_o(mst),
    .transmit_direction_status_o(trx), .service_pending_flag_o(pin),
    .word_bit_count_o(bc), .serial_bus_interrupt_o(irq));
  i2csl_master_mdl mdl_u (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w),
    .scl_o(scl_m), .sda_o(sda_m));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] ad, input int d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= ad;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic t_reset;
    chk({mst, trx, pin, bc, scl_oe, sda_oe}, 8'h20);
    chk({scl_lv, sda_lv}, 2'b00);
    wb(1'b0, OFS_BUS_STATUS, 0);
    chk(rdat, 32'h10);
    wb(1'b0, 8'h20, 0);
    chk(rdat, 32'h00);
  endtask : t_reset

  task automatic t_write;
    wb(1'b1, OFS_OWN_ADDRESS, 32'hA0);
    n = irq_n;
    mdl_u.start();
    mdl_u.put_byte(8'hA0, a);
    chk(a, 0);
    chk(irq_n - n, 1);
    chk({scl_oe, pin}, 2'b10);
    wb(1'b0, OFS_BUS_STATUS, 0);
    chk(rdat & 32'h5E, 32'h04);
    wb(1'b1, OFS_DATA_BUFFER, 0);
    cnt = 0;
    while (scl_oe === 1'b1 && cnt < 100) begin
      @(posedge clk_i);
      cnt++;
    end
    chk(cnt >= LOWC - 1 && cnt <= LOWC + 1, 1);
    mdl_u.put_byte(8'h3C, a);
    chk(irq_n - n, 2);
    wb(1'b0, OFS_DATA_BUFFER, 0);
    chk(rdat, 32'h3C);
    wb(1'b1, OFS_DATA_BUFFER, 0);
    mdl_u.stop();
  endtask : t_write

  task automatic t_gcall;
    n = irq_n;
    mdl_u.start();
    mdl_u.put_byte(8'h00, a);
    chk(a, 0);
    chk(irq_n - n, 1);
    wb(1'b0, OFS_BUS_STATUS, 0);
    chk(rdat & 32'h1E, 32'h06);
    wb(1'b1, OFS_BUS_CONTROL_TWO, 32'h10);
    chk(pin, 1);
    mdl_u.stop();
  endtask : t_gcall

  task automatic t_read;
    n = irq_n;
    mdl_u.start();
    mdl_u.put_byte(8'hA1, a);
    chk({a, trx}, 2'b01);
    wb(1'b1, OFS_DATA_BUFFER, 32'h96);
    mdl_u.get_byte(1'b1, b);
    chk(b, 8'h96);
    chk(irq_n - n, 2);
    wb(1'b0, OFS_BUS_STATUS, 0);
    chk(rdat & 32'h41, 32'h41);
    wb(1'b1, OFS_BUS_CONTROL_TWO, 32'h10);
    chk(trx, 0);
    mdl_u.stop();
  endtask : t_read

  task automatic t_noack;
    n = irq_n;
    wb(1'b1, OFS_BUS_CONTROL_ONE, 32'h15);
    chk(bc, 3'h5);
    mdl_u.start();
    mdl_u.put_byte(8'hA0, a);
    chk(a, 1);
    chk(irq_n - n, 0);
    mdl_u.stop();
    wb(1'b1, OFS_BUS_CONTROL_ONE, 0);
  endtask : t_noack

  task automatic t_arb;
    wb(1'b1, OFS_BUS_CONTROL_TWO, 32'h90);
    chk(mst, 1);
    arb <= 1'b1;
    @(posedge clk_i);
    arb <= 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    chk(mst, 0);
    n = irq_n;
    mdl_u.start();
    mdl_u.put_byte(8'h22, a);
    chk(irq_n - n, 1);
    chk({scl_oe, pin}, 2'b10);
    wb(1'b0, OFS_BUS_STATUS, 0);
    chk(rdat & 32'h1C, 32'h08);
    wb(1'b1, OFS_DATA_BUFFER, 0);
    wb(1'b0, OFS_BUS_STATUS, 0);
    chk(rdat & 32'h18, 32'h10);
    mdl_u.stop();
  endtask : t_arb

  // Own address zero: a start byte must match as a read
  task automatic t_sbyte;
    wb(1'b1, OFS_OWN_ADDRESS, 32'h00);
    n = irq_n;
    mdl_u.start();
    mdl_u.put_byte(8'h01, a);
    chk({a, trx}, 2'b01);
    chk(irq_n - n, 1);
    wb(1'b1, OFS_BUS_CONTROL_TWO, 32'h10);
    mdl_u.stop();
  endtask : t_sbyte

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Counted on the falling edge, away from the launch edge, so tasks never race the increment
  always @(negedge clk_i) if (irq === 1'b1) irq_n++;

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 8'h00;
    wdat  = 32'h0;
    arb   = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_write();
    t_gcall();
    t_read();
    t_noack();
    t_arb();
    t_sbyte();
    tally_and_finish();
  end

  // Whole run is about a thousand cycles; the 30000-cycle limit leaves wide margin
  initial begin
    #(40 * 30000);
    miscompares++;
    tally_and_finish();
  end
endmodule : i2csl_slave_tb_top
